// file: bench/cpu_io_model.sv
// cpu core model issuing i/o register accesses to the eeprom control
`timescale 1ns/1ps
`default_nettype none
module cpu_io_model (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic [7:0] i_rdata,
  output var nv_ctrl_pkg::io_req_t o_io
);
  int stall_cycles = 0;

  // count cycles in which the core is held
  always @(posedge i_clk) begin
    if (i_stall === 1'b1) stall_cycles++;
  end

  // one bus cycle; a halted core issues nothing until the stall ends or 16 cycles pass
  task automatic access(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    while (i_stall !== 1'b0 && n < 16) begin
      n++;
      @(negedge i_clk);
    end
    o_io = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge i_clk);
    o_io = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d}; // released bus shows junk
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    access(a, 1'b1, d);
  endtask

  // read data is taken one cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    access(a, 1'b0, 8'h00);
    @(negedge i_clk);
    d = i_rdata;
  endtask

  // master enable first, program enable inside its window, same mode both times
  task automatic prog(input logic [1:0] m);
    wr(nv_ctrl_pkg::CTRL_OFS, {2'h0, m, 4'hc});
    wr(nv_ctrl_pkg::CTRL_OFS, {2'h0, m, 4'ha});
  endtask

  initial o_io = '0;
endmodule
`default_nettype wire

// file: bench/tb_nv_prog_ctrl.sv
// self-checking bench for the data eeprom program control
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_nv_prog_ctrl;
  localparam int ATOM = 20;
  localparam int SPLT = 10;
  typedef struct {logic [1:0] m; logic [7:0] d; logic [7:0] e; int c;} op_t;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_global_irq_en = 1'b1;
  nv_ctrl_pkg::io_req_t io;
  logic [7:0] o_io_rdata;
  logic o_irq;
  logic o_cpu_stall;
  int mismatches = 0;
  int total_checks = 0;
  int n;
  logic [7:0] v;
  op_t ops [5] = '{
    '{2'h0, 8'ha5, 8'ha5, ATOM},
    '{2'h1, 8'h00, 8'hff, SPLT},
    '{2'h2, 8'h3c, 8'h3c, SPLT},
    '{2'h2, 8'hf0, 8'h30, SPLT},
    '{2'h3, 8'h00, 8'h30, SPLT}};

  // free-running system clock
  always #10 i_clk = ~i_clk;

  nv_prog_ctrl #(.ATOMIC_CYC(ATOM), .SPLIT_CYC(SPLT)) nv_prog_ctrl_i (.i_clk(i_clk),
    .i_srst(i_srst), .i_io(io), .o_io_rdata(o_io_rdata), .i_global_irq_en(i_global_irq_en),
    .o_irq(o_irq), .o_cpu_stall(o_cpu_stall));

  cpu_io_model cpu_io_model_i (.i_clk(i_clk), .i_stall(o_cpu_stall), .i_rdata(o_io_rdata),
    .o_io(io));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    cpu_io_model_i.rd(a, v);
    `CHK("register read", e, v)
  endtask

  // cycles with the ready request low after a start
  task automatic wait_ready();
    n = 0;
    while (o_irq !== 1'b1 && n < 100) begin
      n++;
      @(negedge i_clk);
    end
  endtask

  task automatic start(input logic [1:0] m, input logic [7:0] a, input logic [7:0] d);
    cpu_io_model_i.wr(nv_ctrl_pkg::ADDR_OFS, a);
    cpu_io_model_i.wr(nv_ctrl_pkg::DATA_OFS, d);
    cpu_io_model_i.stall_cycles = 0;
    cpu_io_model_i.prog(m);
  endtask

  task automatic read_back(input logic [7:0] a, input logic [7:0] e);
    cpu_io_model_i.wr(nv_ctrl_pkg::ADDR_OFS, a);
    cpu_io_model_i.stall_cycles = 0;
    cpu_io_model_i.wr(nv_ctrl_pkg::CTRL_OFS, 8'h09);
    rd_chk(nv_ctrl_pkg::DATA_OFS, e);
    `CHK("read stall", 4, cpu_io_model_i.stall_cycles)
  endtask

  task automatic pulse_reset();
    i_srst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_srst = 1'b0;
  endtask

  // main sequence
  initial begin
    repeat (20) @(negedge i_clk);
    i_srst = 1'b0;
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h00);
    rd_chk(nv_ctrl_pkg::DATA_OFS, 8'h00);
    rd_chk(6'h00, 8'h00);
    `CHK("irq disabled", 1'b0, o_irq)
    cpu_io_model_i.wr(nv_ctrl_pkg::CTRL_OFS, 8'h08);
    @(negedge i_clk);
    `CHK("irq ready", 1'b1, o_irq)
    i_global_irq_en = 1'b0;
    @(negedge i_clk);
    `CHK("irq global off", 1'b0, o_irq)
    i_global_irq_en = 1'b1;
    // every mode, with its timing, stall and array effect
    foreach (ops[i]) begin
      start(ops[i].m, 8'h10, ops[i].d);
      wait_ready();
      `CHK("busy cycles", ops[i].c, n)
      `CHK("program stall", 2, cpu_io_model_i.stall_cycles)
      read_back(8'h10, ops[i].e);
    end
    // mode, address and read strobe while busy
    start(2'h0, 8'h11, 8'h3c);
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h0a);
    cpu_io_model_i.stall_cycles = 0;
    cpu_io_model_i.wr(nv_ctrl_pkg::CTRL_OFS, 8'h29);
    cpu_io_model_i.wr(nv_ctrl_pkg::ADDR_OFS, 8'h77);
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h0a);
    `CHK("refused read stall", 0, cpu_io_model_i.stall_cycles)
    wait_ready();
    `CHK("ready after busy", 1'b1, o_irq)
    cpu_io_model_i.wr(nv_ctrl_pkg::CTRL_OFS, 8'h09);
    rd_chk(nv_ctrl_pkg::DATA_OFS, 8'h3c);
    // master enable expires, late program enable does nothing
    cpu_io_model_i.wr(nv_ctrl_pkg::CTRL_OFS, 8'h0c);
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h0c);
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h08);
    cpu_io_model_i.wr(nv_ctrl_pkg::CTRL_OFS, 8'h0a);
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h08);
    // reset in mid-program keeps mode and lets the erase finish
    start(2'h1, 8'h20, 8'h00);
    @(negedge i_clk);
    pulse_reset();
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h12);
    n = 0;
    v = 8'h02;
    while (v[1] !== 1'b0 && n < 40) begin
      n++;
      cpu_io_model_i.rd(nv_ctrl_pkg::CTRL_OFS, v);
    end
    `CHK("program flag cleared", 1'b0, v[1])
    read_back(8'h20, 8'hff);
    // idle reset clears the mode bits
    cpu_io_model_i.wr(nv_ctrl_pkg::CTRL_OFS, 8'h30);
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h30);
    pulse_reset();
    rd_chk(nv_ctrl_pkg::CTRL_OFS, 8'h00);
    tally_and_finish();
  end

  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge i_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: src/nv_array.sv
// 256 x 8 data eeprom array with registered read port
`timescale 1ns/1ps
`default_nettype none
module nv_array (
  input wire logic i_clk,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rdata,
  input wire logic i_wr_en,
  input wire logic [1:0] i_mode,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wdata
);
  logic [7:0] mem [0:255];

  // program cell: erase to all ones, write clears bits, atomic replaces
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      unique case (i_mode)
        nv_ctrl_pkg::MODE_ATOMIC: mem[i_wr_addr] <= i_wdata;
        nv_ctrl_pkg::MODE_ERASE: mem[i_wr_addr] <= nv_ctrl_pkg::ERASED_BYTE;
        nv_ctrl_pkg::MODE_WRITE: mem[i_wr_addr] <= mem[i_wr_addr] & i_wdata;
        nv_ctrl_pkg::MODE_RSVD: mem[i_wr_addr] <= mem[i_wr_addr];
      endcase
    end
  end

  // read data out of a register
  always_ff @(posedge i_clk) begin
    if (i_rd_en) begin
      o_rdata <= mem[i_rd_addr];
    end
  end
endmodule
`default_nettype wire

// file: src/nv_ctrl_pkg.sv
// constants, field layout and bus carrier for the data eeprom program control
// Function
// - a program start runs the operation picked by the mode bits: 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// - software writes to the mode bits are dropped while program enable is set.
// - reset clears the mode bits to zero unless programming is still running.
// - with ready interrupt enable and the global enable set the request stands as long as the memory is ready, and never with the enable clear.
// - program enable starts programming only inside the four cycles after master enable was set, and does nothing otherwise.
// - master program enable written to one clears itself four cycles later.
// - program enable stays set for the whole programming time and is then cleared by hardware.
// - each program start stalls the processor for two cycles, or four when the same write also sets the read strobe.
// - a read strobe fetches the addressed byte into the data register within one instruction.
// - each read strobe stalls the processor for four cycles.
// - while programming runs, read strobes are refused and the address register cannot change.
// - the data register supplies the byte to program and holds the byte last read.
// - a reset during programming lets the operation run to its end.
package nv_ctrl_pkg;

  // i/o register offsets
  localparam logic [5:0] CTRL_OFS = 6'h1c;
  localparam logic [5:0] DATA_OFS = 6'h1d;
  localparam logic [5:0] ADDR_OFS = 6'h1e;

  // control register field positions
  localparam int RE_BIT = 0;
  localparam int PE_BIT = 1;
  localparam int MPE_BIT = 2;
  localparam int RIE_BIT = 3;
  localparam int MODE_LO_BIT = 4;
  localparam int MODE_HI_BIT = 5;

  // operation mode encodings
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic RIE_RST = 1'b0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // timing
  localparam int CLK_NS = 20;
  localparam int T_ATOMIC_NS = 3400000;
  localparam int T_SPLIT_NS = 1800000;
  localparam int ATOMIC_CYC = T_ATOMIC_NS / CLK_NS;
  localparam int SPLIT_CYC = T_SPLIT_NS / CLK_NS;
  localparam logic [2:0] MPE_HOLD = 3'h4;
  localparam logic [2:0] PE_STALL = 3'h2;
  localparam logic [2:0] RD_STALL = 3'h4;
  localparam int TMR_W = 18;

  // one cpu access to the i/o space
  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_t;

endpackage

// file: src/nv_prog_ctrl.sv
// data eeprom control: i/o registers, program timing, read strobe and stalls
`timescale 1ns/1ps
`default_nettype none
module nv_prog_ctrl #(
  parameter int ATOMIC_CYC = nv_ctrl_pkg::ATOMIC_CYC,
  parameter int SPLIT_CYC = nv_ctrl_pkg::SPLIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire nv_ctrl_pkg::io_req_t i_io,
  output logic [7:0] o_io_rdata,
  input wire logic i_global_irq_en,
  output logic o_irq,
  output logic o_cpu_stall
);
  localparam int TW = nv_ctrl_pkg::TMR_W;

  logic ctrl_wr;
  logic data_wr;
  logic addr_wr;
  logic mpe_set;
  logic pe_start;
  logic rd_go;
  logic tmr_zero;
  logic [1:0] mode_q;
  logic rie_q;
  logic mpe_q;
  logic [2:0] mpe_cnt_q;
  logic pe_q;
  logic [TW-1:0] tmr_q;
  logic [1:0] run_mode_q;
  logic [7:0] run_data_q;
  logic [7:0] nv_address_q;
  logic [7:0] nv_data_q;
  logic rd_pend_q;
  logic [2:0] stall_q;
  logic arr_wr;
  logic [7:0] arr_rdata;
  logic [7:0] rdata_q;

  // programming time for a mode; reserved takes the short time
  function automatic logic [TW-1:0] prog_cycles(input logic [1:0] mode);
    logic [TW-1:0] n;
    n = TW'(SPLIT_CYC - 1);
    if (mode == nv_ctrl_pkg::MODE_ATOMIC) begin
      n = TW'(ATOMIC_CYC - 1);
    end
    return n;
  endfunction

  // address decode of i/o writes
  assign ctrl_wr = i_io.wr && (i_io.addr == nv_ctrl_pkg::CTRL_OFS);
  assign data_wr = i_io.wr && (i_io.addr == nv_ctrl_pkg::DATA_OFS);
  assign addr_wr = i_io.wr && (i_io.addr == nv_ctrl_pkg::ADDR_OFS);

  // start conditions of the control bits
  assign mpe_set = ctrl_wr && i_io.wdata[nv_ctrl_pkg::MPE_BIT];
  assign pe_start = ctrl_wr && i_io.wdata[nv_ctrl_pkg::PE_BIT] && mpe_q && !pe_q;
  assign rd_go = ctrl_wr && i_io.wdata[nv_ctrl_pkg::RE_BIT] && !pe_q;
  assign tmr_zero = (tmr_q == '0);
  assign arr_wr = pe_q && tmr_zero && (run_mode_q != nv_ctrl_pkg::MODE_RSVD);

  // mode bits: frozen while programming, reset spared while busy
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      if (!pe_q) begin
        mode_q <= nv_ctrl_pkg::MODE_RST;
      end
    end else if (ctrl_wr && !pe_q) begin
      mode_q <= i_io.wdata[nv_ctrl_pkg::MODE_HI_BIT:nv_ctrl_pkg::MODE_LO_BIT];
    end
  end

  // ready interrupt enable
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rie_q <= nv_ctrl_pkg::RIE_RST;
    end else if (ctrl_wr) begin
      rie_q <= i_io.wdata[nv_ctrl_pkg::RIE_BIT];
    end
  end

  // master enable opens a four cycle window, then drops by itself
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mpe_q <= 1'b0;
      mpe_cnt_q <= '0;
    end else if (mpe_set) begin
      mpe_q <= 1'b1;
      mpe_cnt_q <= nv_ctrl_pkg::MPE_HOLD - 3'h1;
    end else if (mpe_q) begin
      if (mpe_cnt_q == '0) begin
        mpe_q <= 1'b0;
      end else begin
        mpe_cnt_q <= mpe_cnt_q - 3'h1;
      end
    end
  end

  // program flag and timer run on through reset once started
  always_ff @(posedge i_clk) begin
    if (pe_q) begin
      if (tmr_zero) begin
        pe_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q - TW'(1);
      end
    end else if (i_srst) begin
      pe_q <= 1'b0;
      tmr_q <= '0;
    end else if (pe_start) begin
      pe_q <= 1'b1;
      tmr_q <= prog_cycles(mode_q);
    end
  end

  // operation and byte latched at the start
  always_ff @(posedge i_clk) begin
    if (i_srst && !pe_q) begin
      run_mode_q <= nv_ctrl_pkg::MODE_RST;
      run_data_q <= nv_ctrl_pkg::DATA_RST;
    end else if (pe_start && !i_srst) begin
      run_mode_q <= mode_q;
      run_data_q <= nv_data_q;
    end
  end

  // address register, held while programming
  always_ff @(posedge i_clk) begin
    if (addr_wr && !pe_q) begin
      nv_address_q <= i_io.wdata;
    end
  end

  // data register: software byte or fetched byte
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      nv_data_q <= nv_ctrl_pkg::DATA_RST;
    end else if (rd_pend_q) begin
      nv_data_q <= arr_rdata;
    end else if (data_wr) begin
      nv_data_q <= i_io.wdata;
    end
  end

  // read strobe fetch pending one cycle behind the array
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= rd_go;
    end
  end

  // processor stall counter
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stall_q <= '0;
    end else if (rd_go) begin
      stall_q <= nv_ctrl_pkg::RD_STALL;
    end else if (pe_start) begin
      stall_q <= nv_ctrl_pkg::PE_STALL;
    end else if (stall_q != '0) begin
      stall_q <= stall_q - 3'h1;
    end
  end

  assign o_cpu_stall = (stall_q != '0);

  // level ready request, gated by both enables
  assign o_irq = rie_q && i_global_irq_en && !pe_q;

  // registered i/o read data; unmapped reads zero, strobe reads zero
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
    end else if (i_io.rd) begin
      unique case (i_io.addr)
        nv_ctrl_pkg::CTRL_OFS: rdata_q <= {2'h0, mode_q, rie_q, mpe_q, pe_q, 1'b0};
        nv_ctrl_pkg::DATA_OFS: rdata_q <= nv_data_q;
        nv_ctrl_pkg::ADDR_OFS: rdata_q <= nv_address_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign o_io_rdata = rdata_q;

  nv_array u_array (
    .i_clk(i_clk),
    .i_rd_en(rd_go),
    .i_rd_addr(nv_address_q),
    .o_rdata(arr_rdata),
    .i_wr_en(arr_wr),
    .i_mode(run_mode_q),
    .i_wr_addr(nv_address_q),
    .i_wdata(run_data_q)
  );

  // ---- checks
  sequence s_stall2;
    o_cpu_stall [*2] ##1 !o_cpu_stall;
  endsequence

  sequence s_stall4;
    o_cpu_stall [*4] ##1 !o_cpu_stall;
  endsequence

  sequence s_mpe_quiet;
    mpe_set ##1 !mpe_set [*4];
  endsequence

  property p_mpe_hold;
    @(posedge i_clk) disable iff (i_srst)
      mpe_set |=> mpe_q [*4];
  endproperty
  a_mpe_hold: assert property (p_mpe_hold) else $error("master enable dropped early");

  property p_mpe_drop;
    @(posedge i_clk) disable iff (i_srst)
      s_mpe_quiet |=> !mpe_q;
  endproperty
  a_mpe_drop: assert property (p_mpe_drop) else $error("master enable not self cleared");

  property p_pe_gated;
    @(posedge i_clk) disable iff (i_srst)
      ctrl_wr && i_io.wdata[nv_ctrl_pkg::PE_BIT] && !mpe_q && !pe_q |=> !pe_q;
  endproperty
  a_pe_gated: assert property (p_pe_gated) else $error("program started without master enable");

  property p_pe_time;
    @(posedge i_clk) disable iff (i_srst)
      pe_start && mode_q == nv_ctrl_pkg::MODE_ATOMIC |=> pe_q && tmr_q == TW'(ATOMIC_CYC - 1);
  endproperty
  a_pe_time: assert property (p_pe_time) else $error("atomic program time wrong");

  property p_pe_split;
    @(posedge i_clk) disable iff (i_srst)
      pe_start && mode_q != nv_ctrl_pkg::MODE_ATOMIC |=> pe_q && tmr_q == TW'(SPLIT_CYC - 1);
  endproperty
  a_pe_split: assert property (p_pe_split) else $error("split program time wrong");

  property p_pe_keep;
    @(posedge i_clk) pe_q && !tmr_zero |=> pe_q;
  endproperty
  a_pe_keep: assert property (p_pe_keep) else $error("program flag dropped early");

  property p_pe_end;
    @(posedge i_clk) pe_q && tmr_zero |=> !pe_q;
  endproperty
  a_pe_end: assert property (p_pe_end) else $error("program flag not cleared at end");

  property p_mode_lock;
    @(posedge i_clk) pe_q && ctrl_wr |=> $stable(mode_q);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("mode changed while programming");

  property p_mode_rst;
    @(posedge i_clk) i_srst && !pe_q |=> mode_q == nv_ctrl_pkg::MODE_RST;
  endproperty
  a_mode_rst: assert property (p_mode_rst) else $error("mode not cleared by reset");

  // request stands whenever both enables are set and the memory is idle
  property p_irq;
    @(posedge i_clk) disable iff (i_srst)
      rie_q && i_global_irq_en && !pe_q |-> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("ready request level wrong");

  // no request with either enable clear or while programming
  property p_irq_off;
    @(posedge i_clk) disable iff (i_srst)
      !rie_q || !i_global_irq_en || pe_q |-> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("ready request while not allowed");

  // a combined read strobe takes the longer read stall, so it is left out here
  property p_stall_pe;
    @(posedge i_clk) disable iff (i_srst)
      pe_start && !rd_go |=> s_stall2;
  endproperty
  a_stall_pe: assert property (p_stall_pe) else $error("program stall not two cycles");

  property p_stall_rd;
    @(posedge i_clk) disable iff (i_srst)
      rd_go |=> s_stall4;
  endproperty
  a_stall_rd: assert property (p_stall_rd) else $error("read stall not four cycles");

  property p_rd_data;
    @(posedge i_clk) disable iff (i_srst)
      rd_go |=> ##1 nv_data_q == $past(arr_rdata);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("fetched byte not in data register");

  property p_busy_block;
    @(posedge i_clk) disable iff (i_srst)
      pe_q && (addr_wr || ctrl_wr) |=> $stable(nv_address_q) && !rd_pend_q;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("access not blocked while busy");

  property p_rsvd;
    @(posedge i_clk) pe_q && run_mode_q == nv_ctrl_pkg::MODE_RSVD |-> !arr_wr;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode changed the array");

endmodule
`default_nettype wire
